// file: include/adc_cfg.svh
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH
`define ADC_ACLK_NS 100
`define ADC_SCLK_NS 800
`define ADC_SCLK_HALF_CYC ((`ADC_SCLK_NS + 2 * `ADC_ACLK_NS - 1) / (2 * `ADC_ACLK_NS))
`define ADC_ACQ_END_WIDE 6'h0f
`define ADC_ACQ_END_NARROW 6'h07
`define ADC_CFG_FIRST 6'h01
`define ADC_CFG_LAST 6'h10
`define ADC_CHAN_AT 6'h03
`define ADC_FSO_AFTER 6'h01
`define ADC_DATA_AFTER 6'h02
`define ADC_DATA_END_AFTER 6'h11
`define ADC_ZERO_AFTER 6'h12
`define ADC_CNT_START 6'h3f
`define ADC_TRAILER 2'h0
`define ADC_SPI_LEAD 8'h00
`define ADC_PIN_IDLE 5'h08
`define ADC_OFS_CTRL 4'h0
`define ADC_OFS_CONFIG 4'h4
`define ADC_OFS_RESULT 4'h8
`define ADC_OFS_STATUS 4'hc
`define ADC_CTRL_GO 0
`define ADC_CTRL_WIDE 1
`define ADC_CTRL_HOLD 2
`define ADC_WIDE_RESET 1'h1
`define ADC_HOLD_RESET 1'h1
`define ADC_CONFIG_RESET 16'h0000
`define ADC_ST_BUSY 0
`define ADC_ST_DONE 1
`define ADC_ST_FSO 2
`define ADC_ST_DSP 3
`define ADC_RESP_OKAY 2'h0
`define ADC_RESP_SLVERR 2'h2
`endif

// file: include/adc_link_if.sv
`timescale 1ns/100ps
interface adc_link_if;
  logic sclk;
  logic cs_n;
  logic frame_sync_in;
  logic din;
  logic transfer_width_select;
  logic frame_sync_out;
  logic dout;
  modport device (
    input  sclk,
    input  cs_n,
    input  frame_sync_in,
    input  din,
    input  transfer_width_select,
    output frame_sync_out,
    output dout
  );
  modport host (
    output sclk,
    output cs_n,
    output frame_sync_in,
    output din,
    output transfer_width_select,
    input  frame_sync_out,
    input  dout
  );
endinterface

// file: include/adc_pkg.sv
package adc_pkg;
  typedef logic [13:0] code_type;
  typedef logic [15:0] word_type;
  typedef enum logic [1:0] {
    HOST_IDLE   = 2'b00,
    HOST_SELECT = 2'b01,
    HOST_FRAME  = 2'b10
  } host_state_type;
endpackage

// file: src/adc_device_end.sv
`timescale 1ns/100ps
`include "adc_cfg.svh"
module adc_device_end (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  adc_link_if.device         link,
  input  wire logic [13:0]   sample_code,
  input  wire logic          internal_clock_sel,
  output logic [2:0]         channel_sel,
  output logic [15:0]        config_word,
  output logic               config_valid,
  output logic               acquiring,
  output logic               sample_taken,
  output logic               analog_awake,
  output logic               shutdown,
  output logic               osc_enable,
  output logic               dsp_mode
);

  //////////////////////////////////////////////////////////////////////////////

  logic [4:0]         pins_raw;
  logic [4:0]         pins_meta_q;
  logic [4:0]         pins_q;
  logic               sclk_prev_q;
  logic               cs_prev_q;
  logic               sclk_rise;
  logic               sclk_fall;
  logic               cs_rise;
  logic               cs_fall;
  logic               frame_start;
  logic               active_q;
  logic               wide_q;
  logic [5:0]         cnt_q;
  logic [5:0]         cnt_next;
  logic [5:0]         acq_end;
  logic [15:0]        cfg_shift_q;
  logic [15:0]        result_q;
  logic [23:0]        spi_shift_q;
  logic               spi_active_q;
  adc_pkg::code_type  code_q;

  localparam logic [4:0] PIN_IDLE = `ADC_PIN_IDLE;

  assign pins_raw = {link.sclk, link.cs_n, link.frame_sync_in, link.din,
                     link.transfer_width_select};

  // Every link pin is foreign to aclk, so each passes two flops first.
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pins_meta_q[gi] <= PIN_IDLE[gi];
          pins_q[gi]      <= PIN_IDLE[gi];
        end else begin
          pins_meta_q[gi] <= pins_raw[gi];
          pins_q[gi]      <= pins_meta_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
    end else begin
      sclk_prev_q <= pins_q[4];
      cs_prev_q   <= pins_q[3];
    end
  end

  assign sclk_rise   = pins_q[4] & ~sclk_prev_q;
  assign sclk_fall   = ~pins_q[4] & sclk_prev_q;
  assign cs_rise     = pins_q[3] & ~cs_prev_q;
  assign cs_fall     = ~pins_q[3] & cs_prev_q;
  // The sync pulse is seen at a falling clock edge, and may come at any time.
  assign frame_start = dsp_mode & ~pins_q[3] & sclk_fall & pins_q[2];
  assign cnt_next    = cnt_q + 6'h01;
  assign acq_end     = wide_q ? `ADC_ACQ_END_WIDE : `ADC_ACQ_END_NARROW;

  //////////////////////////////////////////////////////////////////////////////
  // Mode entry, frame sequencing and shutdown.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dsp_mode <= 1'b0;
      shutdown <= 1'b1;
      active_q <= 1'b0;
      wide_q   <= 1'b1;
      cnt_q    <= 6'h00;
    end else if (cs_rise) begin
      shutdown <= 1'b1;
      active_q <= 1'b0;
    end else if (cs_fall) begin
      dsp_mode <= ~pins_q[2];
      shutdown <= 1'b0;
    end else if (frame_start) begin
      // Select is not needed again while it stays low between frames.
      active_q <= 1'b1;
      wide_q   <= pins_q[0];
      cnt_q    <= 6'h00;
    end else if (active_q && sclk_rise) begin
      cnt_q <= cnt_next;
      if (cnt_next == 6'(acq_end + `ADC_ZERO_AFTER)) begin
        active_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_awake <= 1'b0;
    end else if (cs_rise) begin
      analog_awake <= 1'b0;
    end else if (frame_start || (cs_fall && pins_q[2])) begin
      analog_awake <= 1'b1;
    end
  end

  // The oscillator is only ever on for a byte-mode conversion in internal mode.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_enable <= 1'b0;
    end else begin
      osc_enable <= spi_active_q & internal_clock_sel & ~dsp_mode;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration capture and channel selection.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_shift_q  <= 16'h0000;
      config_word  <= 16'h0000;
      config_valid <= 1'b0;
    end else begin
      config_valid <= 1'b0;
      if (frame_start) begin
        cfg_shift_q <= 16'h0000;
      end else if (active_q && sclk_fall && cnt_q >= `ADC_CFG_FIRST &&
                   cnt_q <= `ADC_CFG_LAST) begin
        cfg_shift_q <= {cfg_shift_q[14:0], pins_q[1]};
        if (cnt_q == `ADC_CFG_LAST) begin
          config_word  <= {cfg_shift_q[14:0], pins_q[1]};
          config_valid <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_sel  <= 3'h0;
      acquiring    <= 1'b0;
      sample_taken <= 1'b0;
      code_q       <= 14'h0000;
    end else begin
      sample_taken <= 1'b0;
      if (cs_rise || frame_start) begin
        acquiring <= 1'b0;
      end else if (active_q && sclk_fall && cnt_q == `ADC_CHAN_AT) begin
        channel_sel <= {cfg_shift_q[1:0], pins_q[1]};
        acquiring   <= 1'b1;
      end else if (active_q && sclk_rise && cnt_next == acq_end) begin
        // The code is passed on unchanged: it is already straight binary.
        code_q       <= sample_code;
        acquiring    <= 1'b0;
        sample_taken <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result shifting for frame-sync mode and for byte mode.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.frame_sync_out <= 1'b0;
      link.dout           <= 1'b0;
      result_q            <= 16'h0000;
      spi_shift_q         <= 24'h000000;
      spi_active_q        <= 1'b0;
    end else if (cs_rise) begin
      link.frame_sync_out <= 1'b0;
      link.dout           <= 1'b0;
      spi_active_q        <= 1'b0;
    end else if (cs_fall && pins_q[2]) begin
      // Byte mode: lead byte of zeros, code, then the two trailer bits.
      spi_shift_q  <= {`ADC_SPI_LEAD, sample_code, `ADC_TRAILER};
      spi_active_q <= 1'b1;
      link.dout    <= 1'b0;
    end else if (spi_active_q && sclk_fall) begin
      link.dout   <= spi_shift_q[22];
      spi_shift_q <= {spi_shift_q[22:0], 1'b0};
    end else if (frame_start) begin
      link.frame_sync_out <= 1'b0;
      link.dout           <= 1'b0;
    end else if (active_q && sclk_rise) begin
      if (cnt_next == 6'(acq_end + `ADC_FSO_AFTER)) begin
        link.frame_sync_out <= 1'b1;
        result_q            <= {code_q, `ADC_TRAILER};
      end else if (cnt_next >= 6'(acq_end + `ADC_DATA_AFTER) &&
                   cnt_next <= 6'(acq_end + `ADC_DATA_END_AFTER)) begin
        link.frame_sync_out <= 1'b0;
        link.dout           <= result_q[15];
        result_q            <= {result_q[14:0], 1'b0};
      end else if (cnt_next == 6'(acq_end + `ADC_ZERO_AFTER)) begin
        link.dout <= 1'b0;
      end
    end
  end

endmodule

// file: src/adc_host_end.sv
`timescale 1ns/100ps
`include "adc_cfg.svh"
module adc_host_end #(
  parameter int unsigned SCLK_HALF = `ADC_SCLK_HALF_CYC
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  adc_link_if.host          link,
  input  wire logic [3:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [3:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready
);

  //////////////////////////////////////////////////////////////////////////////

  adc_pkg::host_state_type  state_q;
  logic [3:0]               awaddr_q;
  logic [31:0]              wdata_q;
  logic [3:0]               wstrb_q;
  logic                     wr_fire;
  logic                     wide_q;
  logic                     hold_q;
  logic                     go;
  adc_pkg::word_type        cfg_q;
  adc_pkg::word_type        result_q;
  adc_pkg::word_type        shift_q;
  logic                     done_q;
  logic                     done_set;
  logic                     fso_seen_q;
  logic [7:0]               div_q;
  logic                     tick;
  logic [5:0]               hcnt_q;
  logic [5:0]               hnext;
  logic [5:0]               acq_end;
  logic [1:0]               dout_meta_q;
  logic [1:0]               in_q;

  assign wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign go      = wr_fire & (awaddr_q == `ADC_OFS_CTRL) & wstrb_q[0] &
                   wdata_q[`ADC_CTRL_GO];
  assign tick    = (state_q != adc_pkg::HOST_IDLE) & (div_q == 8'h00);
  assign hnext   = hcnt_q + 6'h01;
  assign acq_end = link.transfer_width_select ? `ADC_ACQ_END_WIDE : `ADC_ACQ_END_NARROW;

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ADC_RESP_OKAY;
      awaddr_q      <= 4'h0;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q == `ADC_OFS_RESULT) ? `ADC_RESP_SLVERR : `ADC_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `ADC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `ADC_RESP_OKAY;
      unique case (s_axi_araddr)
        `ADC_OFS_CTRL:   s_axi_rdata <= {29'h0, hold_q, wide_q, 1'b0};
        `ADC_OFS_CONFIG: s_axi_rdata <= {16'h0, cfg_q};
        `ADC_OFS_RESULT: s_axi_rdata <= {16'h0, result_q};
        `ADC_OFS_STATUS: s_axi_rdata <= {28'h0, ~link.cs_n, fso_seen_q, done_q,
                                         state_q != adc_pkg::HOST_IDLE};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `ADC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wide_q <= `ADC_WIDE_RESET;
      hold_q <= `ADC_HOLD_RESET;
      cfg_q  <= `ADC_CONFIG_RESET;
    end else if (wr_fire && awaddr_q == `ADC_OFS_CTRL && wstrb_q[0]) begin
      wide_q <= wdata_q[`ADC_CTRL_WIDE];
      hold_q <= wdata_q[`ADC_CTRL_HOLD];
    end else if (wr_fire && awaddr_q == `ADC_OFS_CONFIG) begin
      if (wstrb_q[0]) cfg_q[7:0] <= wdata_q[7:0];
      if (wstrb_q[1]) cfg_q[15:8] <= wdata_q[15:8];
    end
  end

  // A finishing frame wins over a write-one clear in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
    end else if (done_set) begin
      done_q <= 1'b1;
    end else if (wr_fire && awaddr_q == `ADC_OFS_STATUS && wstrb_q[0] &&
                 wdata_q[`ADC_ST_DONE]) begin
      done_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link engine: makes the serial clock and runs one frame per go.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dout_meta_q <= 2'h0;
      in_q        <= 2'h0;
      div_q       <= 8'h00;
    end else begin
      dout_meta_q <= {link.frame_sync_out, link.dout};
      in_q        <= dout_meta_q;
      div_q       <= (tick || state_q == adc_pkg::HOST_IDLE) ? 8'(SCLK_HALF - 1) :
                     div_q - 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q                    <= adc_pkg::HOST_IDLE;
      link.sclk                  <= 1'b0;
      link.cs_n                  <= 1'b1;
      link.frame_sync_in         <= 1'b0;
      link.din                   <= 1'b0;
      link.transfer_width_select <= `ADC_WIDE_RESET;
      hcnt_q                     <= `ADC_CNT_START;
      shift_q                    <= 16'h0000;
      result_q                   <= 16'h0000;
      fso_seen_q                 <= 1'b0;
      done_set                   <= 1'b0;
    end else begin
      done_set <= 1'b0;
      unique case (state_q)
        adc_pkg::HOST_IDLE: begin
          if (go) begin
            // The width register is written in this same cycle, so take it from the write.
            link.transfer_width_select <= wdata_q[`ADC_CTRL_WIDE];
            hcnt_q                     <= `ADC_CNT_START;
            fso_seen_q                 <= 1'b0;
            if (link.cs_n) begin
              // Sync held low while select falls picks frame-sync mode.
              link.cs_n <= 1'b0;
              state_q   <= adc_pkg::HOST_SELECT;
            end else begin
              link.frame_sync_in <= 1'b1;
              state_q            <= adc_pkg::HOST_FRAME;
            end
          end else if (!hold_q) begin
            link.cs_n <= 1'b1;
          end
        end
        adc_pkg::HOST_SELECT: begin
          if (tick) begin
            link.frame_sync_in <= 1'b1;
            state_q            <= adc_pkg::HOST_FRAME;
          end
        end
        default: begin
          if (tick && link.sclk) begin
            link.sclk <= 1'b0;
          end else if (tick) begin
            // Data are read just before the next rise, clear of sync delays.
            if (hcnt_q >= 6'(acq_end + `ADC_DATA_AFTER) &&
                hcnt_q <= 6'(acq_end + `ADC_DATA_END_AFTER)) begin
              shift_q <= {shift_q[14:0], in_q[0]};
            end
            if (hcnt_q == 6'(acq_end + `ADC_DATA_END_AFTER)) begin
              result_q <= {shift_q[14:0], in_q[0]};
              done_set <= 1'b1;
              state_q  <= adc_pkg::HOST_IDLE;
            end else begin
              link.sclk <= 1'b1;
              hcnt_q    <= hnext;
              if (hnext == `ADC_CFG_FIRST) begin
                link.frame_sync_in <= 1'b0;
              end
              if (hnext >= `ADC_CFG_FIRST && hnext <= `ADC_CFG_LAST) begin
                link.din <= cfg_q[4'(`ADC_CFG_LAST - hnext)];
              end else begin
                link.din <= 1'b0;
              end
              if (hnext == 6'(acq_end + `ADC_DATA_AFTER)) begin
                fso_seen_q <= in_q[1];
              end
            end
          end
        end
      endcase
    end
  end

endmodule

// file: tb/adc_dsp_serial_frame_port_tb_top.sv
`timescale 1ns/100ps
module adc_dsp_serial_frame_port_tb_top;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, internal_clock_sel;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [13:0] sample_code;
  logic [2:0]  channel_sel;
  logic [15:0] config_word;
  logic        config_valid, acquiring, sample_taken, analog_awake, shutdown;
  logic        osc_enable, dsp_mode;
  int          num_errors, n_compared;
  adc_link_if link ();
  adc_device_end adc_device_end_i (.aclk, .aresetn, .link(link), .sample_code,
    .internal_clock_sel, .channel_sel, .config_word, .config_valid, .acquiring,
    .sample_taken, .analog_awake, .shutdown, .osc_enable, .dsp_mode);
  adc_host_end #(.SCLK_HALF(4)) adc_host_end_i (.aclk, .aresetn, .link(link),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  adc_link_monitor adc_link_monitor_i (.aclk, .aresetn, .sclk(link.sclk), .cs_n(link.cs_n),
    .frame_sync_in(link.frame_sync_in), .transfer_width_select(link.transfer_width_select),
    .frame_sync_out(link.frame_sync_out));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0; aresetn = 1'b0; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
    s_axi_awaddr = 4'h0; s_axi_araddr = 4'h0; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hf;
    internal_clock_sel = 1'b1; sample_code = 14'h0000;
    num_errors = 0; n_compared = 0;
  end
  always #50 aclk = ~aclk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Address and data are offered together and each dropped at its own take.
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    r = s_axi_bresp;
    if (s_axi_bvalid !== 1'b1) num_errors++;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (s_axi_rvalid !== 1'b1) num_errors++;
    s_axi_rready <= 1'b0;
  endtask
  // One conversion with select held low; status is polled, never timed.
  task automatic run_frame(input logic [15:0] cfg, input logic wide, input logic [13:0] code);
    int n;
    n = 0;
    sample_code <= code;
    axi_write(4'h4, {16'h0, cfg}, rs);
    axi_write(4'h0, {29'h0, 1'b1, wide, 1'b1}, rs);
    do begin
      axi_read(4'hc, rd, rs);
      n++;
    end while (rd[1] !== 1'b1 && n < 400);
    check("done", {31'h0, rd[1]}, 32'h1);
    check("fso seen", {31'h0, rd[2]}, 32'h1);
    check("width select", {31'h0, link.transfer_width_select}, {31'h0, wide});
    axi_read(4'h8, rd, rs);
    check("result", rd, {16'h0, code, 2'b00});
    check("config word", {16'h0, config_word}, {16'h0, cfg});
    check("channel", {29'h0, channel_sel}, {29'h0, cfg[15:13]});
    check("dsp mode", {31'h0, dsp_mode}, 32'h1);
    check("oscillator", {31'h0, osc_enable}, 32'h0);
    axi_write(4'hc, 32'h2, rs);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(4'h0, rd, rs);
    check("ctrl reset", rd, 32'h6);
    axi_read(4'h4, rd, rs);
    check("config reset", rd, 32'h0);
    axi_read(4'h2, rd, rs);
    check("unmapped resp", {30'h0, rs}, 32'h2);
    axi_write(4'h8, 32'h1, rs);
    check("result write resp", {30'h0, rs}, 32'h2);
    check("shutdown reset", {31'h0, shutdown}, 32'h1);
    run_frame(16'ha5c3, 1'b1, 14'h2a5c);
    run_frame(16'h3c5a, 1'b1, 14'h3fff);
    check("select held", {31'h0, link.cs_n}, 32'h0);
    run_frame(16'h6001, 1'b0, 14'h0001);
    axi_read(4'hc, rd, rs);
    check("done cleared", rd & 32'h3, 32'h0);
    axi_write(4'h0, 32'h2, rs);
    n = 0;
    while (shutdown !== 1'b1 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    check("shutdown", {31'h0, shutdown}, 32'h1);
    check("select high", {31'h0, link.cs_n}, 32'h1);
    run_frame(16'hffff, 1'b1, 14'h0000);
    check("awake again", {31'h0, shutdown}, 32'h0);
    tally_and_finish();
  end
  initial begin
    repeat (10000) @(posedge aclk);
    num_errors++;
    tally_and_finish();
  end
endmodule

// file: tb/adc_link_monitor.sv
`timescale 1ns/100ps
module adc_link_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic frame_sync_in,
  input wire logic transfer_width_select,
  input wire logic frame_sync_out
);
  logic       sclk_q;
  logic [5:0] rise_cnt_q;
  logic       rise;
  logic       frame_wide_q;
  assign rise = sclk & ~sclk_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end
  // Rise 0 is the one seen with the input sync still high; 3f means no frame yet.
  always_ff @(posedge aclk) begin
    if (!aresetn) rise_cnt_q <= 6'h3f;
    else if (rise && frame_sync_in) rise_cnt_q <= 6'h00;
    else if (rise && rise_cnt_q != 6'h3f) rise_cnt_q <= rise_cnt_q + 6'h01;
  end
  // Width is taken at rise 0, since the host may change it between frames.
  always_ff @(posedge aclk) begin
    if (!aresetn) frame_wide_q <= 1'b1;
    else if (rise && frame_sync_in) frame_wide_q <= transfer_width_select;
  end
  //////////////////////////////////////////////////////////////////////////////
  chk_fso_rise_count: assert property (
    $rose(frame_sync_out) |-> rise_cnt_q == (transfer_width_select ? 6'h10 : 6'h08))
    else $error("output frame sync at wrong clock");
  chk_fso_one_period: assert property (
    $rose(frame_sync_out) |-> frame_sync_out [*8] ##1 !frame_sync_out)
    else $error("output frame sync width wrong");
  chk_fso_selected: assert property (
    $rose(frame_sync_out) |-> !cs_n)
    else $error("output frame sync while deselected");
  chk_sync_ends_rise: assert property (
    $fell(frame_sync_in) |-> $rose(sclk))
    else $error("input sync not ended at clock rise");
  chk_select_sync_low: assert property (
    $fell(cs_n) |-> !frame_sync_in)
    else $error("select fell with sync high");
  chk_clock_high_time: assert property (
    $rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock high time wrong");
  chk_clock_parked: assert property (
    cs_n |-> !sclk)
    else $error("serial clock runs while deselected");
  chk_frame_length: assert property (
    rise_cnt_q == 6'h3f || rise_cnt_q <= (frame_wide_q ? 6'h20 : 6'h18))
    else $error("frame too long");
  cover property ($rose(frame_sync_out) && transfer_width_select);
  cover property ($rose(frame_sync_out) && !transfer_width_select);
  cover property ($rose(cs_n));
endmodule
